// ### common/aeqt_pkg.sv
// Shared constants for the adaptive equalization tuning register bank
package aeqt_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] AEQT_IDX_CONTROL = 8'h1c;
    localparam logic [7:0] AEQT_IDX_TUNING = 8'h1d;
    localparam logic [7:0] AEQT_IDX_LONG = 8'h1e;
    localparam logic [7:0] AEQT_IDX_STATUS = 8'h1f;
    localparam logic [7:0] AEQT_IDX_DSRX = 8'h20;
    localparam logic [7:0] AEQT_IDX_APPLIED = 8'h24;

    // Reset values
    localparam logic [7:0] AEQT_RST_CONTROL = 8'hf0;
    localparam logic [7:0] AEQT_RST_TUNING = 8'h20;
    localparam logic [7:0] AEQT_RST_LONG = 8'h77;
    localparam logic [7:0] AEQT_RST_DSRX = 8'h00;

    // Control register fields
    localparam int AEQT_CTL_ENABLE_BIT = 0;
    localparam int AEQT_CTL_METHOD_LO = 1;
    localparam int AEQT_CTL_METHOD_HI = 2;

    // Tuning register fields
    localparam int AEQT_TUN_SIGN_BIT = 7;
    localparam int AEQT_TUN_RSVD_BIT = 6;
    localparam int AEQT_TUN_THR_LO = 3;
    localparam int AEQT_TUN_THR_HI = 5;
    localparam int AEQT_TUN_OFS_LO = 0;
    localparam int AEQT_TUN_OFS_HI = 2;

    // Per-receiver code nibbles, shared by the long, short and applied registers
    localparam int AEQT_RXA_LO = 0;
    localparam int AEQT_RXA_HI = 3;
    localparam int AEQT_RXB_LO = 4;
    localparam int AEQT_RXB_HI = 7;

    // Status register bits
    localparam int AEQT_STS_LONG_BIT = 0;
    localparam int AEQT_STS_FULL_BIT = 1;
    localparam int AEQT_STS_FAST_BIT = 2;

    // Threshold step and equalization code range
    localparam int AEQT_THR_STEP_MV = 40;
    localparam logic [3:0] AEQT_EQ_MAX = 4'hf;
    localparam logic signed [5:0] AEQT_NEG_BIAS = 6'sh08;

    // Adaptation method codes (low bit clear means fast)
    typedef enum logic [1:0]
    {
        AEQT_METHOD_FAST0 = 2'b00,
        AEQT_METHOD_FULL_EVERY = 2'b01,
        AEQT_METHOD_FAST2 = 2'b10,
        AEQT_METHOD_FULL_ZERO = 2'b11
    } aeqt_method_e;

endpackage

// ### design/aeqt_regs.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// - The top bit of the tuning register makes the offset additive when 0, subtractive when 1.
// - Tuning bits 5:3 pick the short/long window as plus or minus code times 40 mV, reset 4.
// - Tuning bits 2:0 give the offset, n when positive and n minus eight when negative.
// - The offset is applied only in full adaptation and ignored in fast mode or when off.
// - Long-channel upper nibble is receiver B's code in fast mode on a long channel.
// - Long-channel lower nibble is receiver A's code in fast mode on a long channel.
// - The long-channel register resets to 0x77 and is used only in fast adaptation.
// - The register at index 0x20 holds both receivers' codes and resets to zero.
// - Method field low bit 0 selects fast; 1 and 3 select the two full variants.
// - One enable bit turns adaptation on when set, off when clear, and resets off.
// - In fast mode a short channel applies the index 0x20 codes instead of the long codes.
module aeqt_regs
    import aeqt_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [9:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic signed [9:0] MEAS_LEVEL_MV,
    input wire logic [3:0] FULL_EQ_A,
    input wire logic [3:0] FULL_EQ_B,
    output logic [3:0] RX_A_EQ,
    output logic [3:0] RX_B_EQ,
    output logic LONG_CHANNEL
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] control;
    logic [7:0] tuning;
    logic [7:0] long_codes;
    logic [7:0] dsrx_codes;

    logic [7:0] index;
    logic setup;
    logic access;
    logic wr_stb;
    logic adapt_enable;
    aeqt_method_e adapt_method_select;
    logic fast_active;
    logic full_active;
    logic [8:0] threshold_mv;
    logic [9:0] level_abs;
    logic short_now;
    logic signed [5:0] eq_offset;
    logic [3:0] next_rx_a;
    logic [3:0] next_rx_b;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // Word index from the byte address; low two address bits are ignored
    assign index = PADDR[9:2];
    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE && PREADY;
    assign wr_stb = access && PWRITE;

    // Offset field widened to signed; negative sign subtracts eight
    function automatic logic signed [5:0] offset_value(input logic neg, input logic [2:0] mag);
        logic signed [5:0] v;
        v = signed'({3'b000, mag});
        if (neg)
        begin
            v = v - AEQT_NEG_BIAS;
        end
        return v;
    endfunction

    // Adds the offset to a full result and clamps into 0..15
    function automatic logic [3:0] adjust_clamp(input logic [3:0] eq, input logic signed [5:0] ofs);
        logic signed [5:0] sum;
        sum = signed'({2'b00, eq}) + ofs;
        if (sum < 0)
        begin
            return 4'h0;
        end
        else if (sum > signed'({2'b00, AEQT_EQ_MAX}))
        begin
            return AEQT_EQ_MAX;
        end
        return sum[3:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign adapt_enable = control[AEQT_CTL_ENABLE_BIT];
    assign adapt_method_select =
        aeqt_method_e'(control[AEQT_CTL_METHOD_HI:AEQT_CTL_METHOD_LO]);
    // Low method bit clear means fast whichever the high bit is
    assign fast_active = adapt_enable && !adapt_method_select[0];
    assign full_active = adapt_enable && adapt_method_select[0];

    // Window is symmetric, so compare the magnitude of the measured level
    assign threshold_mv = 9'(control_thr_code() * AEQT_THR_STEP_MV);
    assign level_abs = MEAS_LEVEL_MV[9] ? 10'(-MEAS_LEVEL_MV) : MEAS_LEVEL_MV;
    assign short_now = (level_abs <= {1'b0, threshold_mv});
    assign eq_offset = offset_value(tuning[AEQT_TUN_SIGN_BIT],
                                    tuning[AEQT_TUN_OFS_HI:AEQT_TUN_OFS_LO]);

    function automatic logic [2:0] control_thr_code();
        return tuning[AEQT_TUN_THR_HI:AEQT_TUN_THR_LO];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Applied code selection per receiver
    always_comb
    begin
        next_rx_a = dsrx_codes[AEQT_RXA_HI:AEQT_RXA_LO];
        next_rx_b = dsrx_codes[AEQT_RXB_HI:AEQT_RXB_LO];
        if (full_active)
        begin
            // Offset only matters here; fast and off paths never see it
            next_rx_a = adjust_clamp(FULL_EQ_A, eq_offset);
            next_rx_b = adjust_clamp(FULL_EQ_B, eq_offset);
        end
        else if (fast_active && !short_now)
        begin
            next_rx_a = long_codes[AEQT_RXA_HI:AEQT_RXA_LO];
            next_rx_b = long_codes[AEQT_RXB_HI:AEQT_RXB_LO];
        end
        else if (fast_active)
        begin
            next_rx_a = dsrx_codes[AEQT_RXA_HI:AEQT_RXA_LO];
            next_rx_b = dsrx_codes[AEQT_RXB_HI:AEQT_RXB_LO];
        end
    end

    // Receiver code outputs, one cycle behind the inputs
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            RX_A_EQ <= 4'h0;
            RX_B_EQ <= 4'h0;
            LONG_CHANNEL <= 1'b0;
        end
        else
        begin
            RX_A_EQ <= next_rx_a;
            RX_B_EQ <= next_rx_b;
            LONG_CHANNEL <= fast_active && !short_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written registers; writes land at the access edge
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            control <= AEQT_RST_CONTROL;
            tuning <= AEQT_RST_TUNING;
            long_codes <= AEQT_RST_LONG;
            dsrx_codes <= AEQT_RST_DSRX;
        end
        else if (wr_stb)
        begin
            case (index)
                AEQT_IDX_CONTROL: control <= PWDATA[7:0];
                // Reserved bit is kept at zero so it reads back as zero
                AEQT_IDX_TUNING: tuning <= PWDATA[7:0] & ~(8'h01 << AEQT_TUN_RSVD_BIT);
                AEQT_IDX_LONG: long_codes <= PWDATA[7:0];
                AEQT_IDX_DSRX: dsrx_codes <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and error decode, captured in the setup cycle
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (index)
            AEQT_IDX_CONTROL: next_prdata[7:0] = control;
            AEQT_IDX_TUNING: next_prdata[7:0] = tuning;
            AEQT_IDX_LONG: next_prdata[7:0] = long_codes;
            AEQT_IDX_DSRX: next_prdata[7:0] = dsrx_codes;
            AEQT_IDX_STATUS:
            begin
                next_prdata[AEQT_STS_LONG_BIT] = LONG_CHANNEL;
                next_prdata[AEQT_STS_FULL_BIT] = full_active;
                next_prdata[AEQT_STS_FAST_BIT] = fast_active;
            end
            AEQT_IDX_APPLIED: next_prdata[7:0] = {RX_B_EQ, RX_A_EQ};
            default: next_pslverr = 1'b1;
        endcase
    end

    // Registered answer: ready for exactly one access cycle, so every
    // transfer takes the minimum two cycles and outputs stay glitch free
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= setup;
            if (setup)
            begin
                PRDATA <= PWRITE ? 32'h0000_0000 : next_prdata;
                PSLVERR <= next_pslverr;
            end
            else if (access)
            begin
                PRDATA <= 32'h0000_0000;
                PSLVERR <= 1'b0;
            end
        end
    end

endmodule

// ### verification/aeqt_regs_monitor.sv
`timescale 1ns/10ps
// Compares the bank's outputs with a shadow copy built from completed writes
module aeqt_regs_monitor
    import aeqt_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [9:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic signed [9:0] MEAS_LEVEL_MV,
    input wire logic [3:0] FULL_EQ_A,
    input wire logic [3:0] FULL_EQ_B,
    input wire logic [3:0] RX_A_EQ,
    input wire logic [3:0] RX_B_EQ,
    input wire logic LONG_CHANNEL
);
    logic [7:0] c, t, l, d, sh;
    logic [9:0] mag;
    logic [3:0] fa, fb;
    logic ok, um, win, fast, full;
    // Offset is applied in 6 bits so a negative sum is caught before clamping
    function automatic logic [3:0] adj(input logic [3:0] e, input logic [7:0] tv);
        logic [5:0] s;
        s = {2'h0, e} + {3'h0, tv[2:0]} - (tv[7] ? 6'h08 : 6'h00);
        return s[5] ? 4'h0 : (s > 6'h0f ? 4'hf : s[3:0]);
    endfunction
    // Shadow registers change only at the edge that completes a write
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            {c, t, l, d} <= {AEQT_RST_CONTROL, AEQT_RST_TUNING, AEQT_RST_LONG, AEQT_RST_DSRX};
        else if (PSEL && PENABLE && PREADY && PWRITE)
        begin
            case (PADDR[9:2])
                AEQT_IDX_CONTROL: c <= PWDATA[7:0];
                AEQT_IDX_TUNING: t <= PWDATA[7:0] & 8'hbf;
                AEQT_IDX_LONG: l <= PWDATA[7:0];
                AEQT_IDX_DSRX: d <= PWDATA[7:0];
                default: ;
            endcase
        end
    end
    // Read mux over the stored registers; status and applied are left out
    always_comb
    begin
        ok = 1'b1;
        case (PADDR[9:2])
            AEQT_IDX_CONTROL: sh = c;
            AEQT_IDX_TUNING: sh = t;
            AEQT_IDX_LONG: sh = l;
            AEQT_IDX_DSRX: sh = d;
            default: {ok, sh} = 9'h000;
        endcase
    end
    // Selection inputs; the window edge counts as short
    assign um = !ok && PADDR[9:2] != AEQT_IDX_STATUS && PADDR[9:2] != AEQT_IDX_APPLIED;
    assign mag = MEAS_LEVEL_MV[9] ? -MEAS_LEVEL_MV : MEAS_LEVEL_MV;
    assign win = mag <= {7'h00, t[5:3]} * 10'h028;
    assign fast = c[0] && !c[1];
    assign full = c[0] && c[1];
    assign fa = adj(FULL_EQ_A, t);
    assign fb = adj(FULL_EQ_B, t);
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_setup; PSEL && !PENABLE; endsequence
    property p_ready; s_setup |=> PREADY ##1 !PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
    property p_err; (PSEL && !PENABLE && um) |=> PSLVERR && PRDATA == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_rd; (PSEL && !PENABLE && !PWRITE && ok) |=> PRDATA == {24'h0, $past(sh)}; endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_off; $past(!c[0]) |-> {RX_B_EQ, RX_A_EQ} == $past(d) && !LONG_CHANNEL; endproperty
    a_off: assert property (p_off) else $error("codes wrong with adaptation off");
    property p_short; $past(fast && win) |-> {RX_B_EQ, RX_A_EQ} == $past(d) && !LONG_CHANNEL; endproperty
    a_short: assert property (p_short) else $error("short channel codes wrong");
    property p_long; $past(fast && !win) |-> {RX_B_EQ, RX_A_EQ} == $past(l) && LONG_CHANNEL; endproperty
    a_long: assert property (p_long) else $error("long channel codes wrong");
    property p_full_a; $past(full) |-> RX_A_EQ == $past(fa) && !LONG_CHANNEL; endproperty
    a_full_a: assert property (p_full_a) else $error("full result A wrong");
    property p_full_b; $past(full) |-> RX_B_EQ == $past(fb); endproperty
    a_full_b: assert property (p_full_b) else $error("full result B wrong");
endmodule
bind aeqt_regs aeqt_regs_monitor aeqt_regs_monitor_i (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .MEAS_LEVEL_MV, .FULL_EQ_A, .FULL_EQ_B,
    .RX_A_EQ, .RX_B_EQ, .LONG_CHANNEL);

// ### verification/test_aeqt_regs.sv
`timescale 1ns/10ps
// Register access sequences with expected codes on the receiver outputs
module test_aeqt_regs
    import aeqt_pkg::*;
;
    logic CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [9:0] PADDR = 10'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, LONG_CHANNEL, er;
    logic signed [9:0] MEAS_LEVEL_MV = 10'sh000;
    logic [3:0] FULL_EQ_A = 4'h6, FULL_EQ_B = 4'he, RX_A_EQ, RX_B_EQ;
    logic [7:0] tt [3] = '{8'h02, 8'h80, 8'h87};
    logic [7:0] ee [3] = '{8'hf8, 8'h60, 8'hd5};
    int err_total = 0, n_compared = 0;
    always #50 CLK = ~CLK;
    aeqt_regs aeqt_regs_i (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .MEAS_LEVEL_MV, .FULL_EQ_A, .FULL_EQ_B, .RX_A_EQ, .RX_B_EQ,
        .LONG_CHANNEL);
    ////////////////////////////////////////////////////////////////////////////////
    task results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request stands until ready is seen at an edge
    task apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= {ix, 2'h0};
        PWDATA <= {24'h0, wd};
        @(posedge CLK);
        PENABLE <= 1'b1;
        // Look at ready once it has settled, so the value seen is the one the next edge samples
        #1;
        while (PREADY !== 1'b1)
        begin
            k++;
            if (k > 9)
            begin
                err_total++;
                results();
            end
            @(posedge CLK);
            #1;
        end
        // Answer stands until the completing edge; release only after that edge
        rd = PRDATA;
        er = PSLVERR;
        @(posedge CLK);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task rdc(input logic [7:0] ix, input logic [7:0] ex);
        apb(1'b0, ix, 8'h00);
        check(rd, {24'h0, ex});
    endtask
    // Outputs settle one edge after their cause; two edges leave margin
    task eqc(input logic [7:0] ex, input logic lc);
        repeat (2) @(posedge CLK);
        #1;
        check({20'h0, RX_B_EQ, RX_A_EQ, 3'h0, LONG_CHANNEL}, {20'h0, ex, 3'h0, lc});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        rdc(AEQT_IDX_CONTROL, 8'hf0);
        rdc(AEQT_IDX_TUNING, 8'h20);
        rdc(AEQT_IDX_LONG, 8'h77);
        rdc(AEQT_IDX_DSRX, 8'h00);
        eqc(8'h00, 1'b0);
        apb(1'b0, 8'h30, 8'h00);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        $display("reset test done");
        // Adaptation off passes the receiver codes straight through
        apb(1'b1, AEQT_IDX_DSRX, 8'h5a);
        apb(1'b1, AEQT_IDX_LONG, 8'h3c);
        rdc(AEQT_IDX_LONG, 8'h3c);
        eqc(8'h5a, 1'b0);
        // Fast mode at each window edge; the offset is loaded but must be ignored
        apb(1'b1, AEQT_IDX_CONTROL, 8'h01);
        for (int n = 0; n < 8; n++)
        begin
            apb(1'b1, AEQT_IDX_TUNING, 8'hc7 | 8'(n * 8));
            rdc(AEQT_IDX_TUNING, 8'h87 | 8'(n * 8));
            MEAS_LEVEL_MV <= 10'(-n * 40);
            eqc(8'h5a, 1'b0);
            MEAS_LEVEL_MV <= 10'(n * 40 + 1);
            eqc(8'h3c, 1'b1);
        end
        apb(1'b1, AEQT_IDX_CONTROL, 8'h05);
        eqc(8'h3c, 1'b1);
        // Status shows a long channel in fast mode; applied codes read back
        rdc(AEQT_IDX_STATUS, 8'h05);
        rdc(AEQT_IDX_APPLIED, 8'h3c);
        $display("fast test done");
        // Both full methods, offsets of either sign, clamping at both ends
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, AEQT_IDX_CONTROL, i < 3 ? 8'h03 : 8'h07);
            apb(1'b1, AEQT_IDX_TUNING, tt[i % 3]);
            eqc(ee[i % 3], 1'b0);
        end
        $display("full test done");
        // Reset in mid-run restores the long-channel codes
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        rdc(AEQT_IDX_LONG, 8'h77);
        $display("second reset test done");
        results();
    end
endmodule
